// ---- verilog/flash_pins_pkg.sv ----
package flash_pins_pkg;

	// ************************************************************
	// Array geometry
	// ************************************************************
	localparam int ADDR_W = 18;
	localparam int PAGE_BYTES = 256;
	localparam int PAGE_COUNT = 1024;
	localparam int SECTOR_COUNT = 64;
	localparam int SECTOR_BYTES = 4096;
	localparam int BLOCK32_BYTES = 32768;
	localparam int BLOCK64_BYTES = 65536;
	localparam int BLOCK64_COUNT = 4;
	localparam int HOST_ADDR_BITS = 24;
	localparam int UNIQUE_ID_BITS = 64;

	// ************************************************************
	// Serial framing counts, in bits, and the continuous-mode code
	// ************************************************************
	localparam logic [5:0] BYTE_BITS = 6'h08;
	localparam logic [5:0] ADDR_BITS = 6'h18;
	localparam logic [5:0] FAST_DUMMY_BITS = 6'h08;
	localparam logic [5:0] UID_DUMMY_BITS = 6'h20;
	localparam logic [1:0] CONT_MODE_CODE = 2'h2;

	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_DOUT = 8'h3B;
	localparam logic [7:0] OP_DIO = 8'hBB;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_ERASE4K = 8'h20;
	localparam logic [7:0] OP_ERASE32K = 8'h52;
	localparam logic [7:0] OP_ERASE64K = 8'hD8;
	localparam logic [7:0] OP_CHIP_A = 8'hC7;
	localparam logic [7:0] OP_CHIP_B = 8'h60;
	localparam logic [7:0] OP_MFR_DEV = 8'h90;
	localparam logic [7:0] OP_UID = 8'h4B;
	localparam logic [7:0] OP_JEDEC = 8'h9F;

	// ************************************************************
	// Status byte layout and reset value
	// ************************************************************
	localparam int SR_BUSY = 0;
	localparam int SR_WEL = 1;
	localparam int SR_RANGE_LO = 2;
	localparam int SR_RANGE_HI = 3;
	localparam int SR_FROM_BOTTOM = 5;
	localparam int SR_LOCK = 7;
	localparam logic [7:0] SR_WRITE_MASK = 8'hAC;
	localparam logic [7:0] SR_RESET = 8'h00;

	// ************************************************************
	// Enumerations
	// ************************************************************
	typedef enum logic [1:0] {
		ERASE_4K = 2'h0,
		ERASE_32K = 2'h1,
		ERASE_64K = 2'h2,
		ERASE_CHIP = 2'h3
	} erase_kind_type;

	typedef enum logic [2:0] {
		SRC_MEM = 3'h0,
		SRC_STAT = 3'h1,
		SRC_JEDEC = 3'h2,
		SRC_MFR_DEV = 3'h3,
		SRC_UID = 3'h4
	} source_type;

	typedef enum logic [6:0] {
		ST_CMD = 7'h01,
		ST_ADDR = 7'h02,
		ST_MODE = 7'h04,
		ST_DUMMY = 7'h08,
		ST_WDATA = 7'h10,
		ST_RDATA = 7'h20,
		ST_IGNORE = 7'h40
	} phase_type;

	// Protected region grows from top or bottom in 64KB steps
	function automatic logic is_protected(input logic [ADDR_W-1:0] addr,
		input logic [1:0] range, input logic from_bottom);
		logic [1:0] blk;
		blk = addr[ADDR_W-1:ADDR_W-2];
		if (range == 2'h0) begin
			is_protected = 1'b0;
		end else if (range == 2'h3) begin
			is_protected = 1'b1;
		end else if (from_bottom) begin
			is_protected = blk < range;
		end else begin
			is_protected = blk >= 2'(3'h4 - {1'b0, range});
		end
	endfunction : is_protected

endpackage : flash_pins_pkg

// ---- verilog/pin_sampler.sv ----
module pin_sampler #(
	parameter int WIDTH = 6,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// Raw pins
	input wire logic [WIDTH-1:0] i_pins,
	// Filtered levels and edge pulses
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_rise,
	output logic [WIDTH-1:0] o_fall
);

	// Refuse an empty pin group at elaboration
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sampler needs at least one pin");
	end

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_q;
	logic [WIDTH-1:0] level_d;

	// A change counts only once stages two and three agree
	assign level_d = (s2_q & s3_q) | (level_q & (s2_q | s3_q));
	assign o_level = level_q;
	assign o_rise = level_d & ~level_q;
	assign o_fall = ~level_d & level_q;

	// Three-stage capture; stage one feeds stage two only
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_q <= IDLE;
			s2_q <= IDLE;
			s3_q <= IDLE;
			level_q <= IDLE;
		end else begin
			s1_q <= i_pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end

endmodule : pin_sampler

// ---- verilog/flash_pin_port.sv ----
// Notes on behaviour
// - Deselected: both data lines float.
// - No instruction before a select falling edge.
// - Single instructions sampled on clock rise.
// - Single read data changes on clock fall.
// - Dual: rise samples in, fall drives out.
// - Write-protect low with lock blocks status writes.
// - Pause floats output, ignores clock and data.
// - Pause release resumes from held state.
// - 1,024 pages, program wraps within 256 bytes.
// - Erase 4KB sectors, 32KB, 64KB blocks.
// - Continuous dual read: 12-clock address, no opcode.
// - Identification bytes and 64-bit unique number.
// - Protected range from top or bottom.
// - Clock idling low or high both work.
// - Pause starts when clock low, else next fall.
// - Pause ends when clock low, else next fall.
module flash_pin_port #(
	parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value
	parameter logic [7:0] MEM_TYPE = 8'h30, // Arbitrary value
	parameter logic [7:0] CAP_ID = 8'h12, // Arbitrary value
	parameter logic [7:0] DEV_ID = 8'h11, // Arbitrary value
	parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF // Arbitrary value
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// Serial pins from the host
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_write_protect_n,
	input wire logic i_pause_n,
	// Two-way data lines
	input wire logic i_dual_line_zero,
	output logic o_dual_line_zero,
	output logic o_dual_line_zero_oe,
	input wire logic i_dual_line_one,
	output logic o_dual_line_one,
	output logic o_dual_line_one_oe,
	// Array back end
	output logic [flash_pins_pkg::ADDR_W-1:0] o_mem_addr,
	output logic o_mem_rd,
	input wire logic [7:0] i_mem_rdata,
	output logic o_mem_wr,
	output logic [7:0] o_mem_wdata,
	output logic o_erase_req,
	output logic [1:0] o_erase_kind,
	input wire logic i_busy,
	// Status view
	output logic [7:0] o_status,
	output logic o_selected,
	output logic o_paused
);

	// Geometry must add up, or the erase bases would land wrong
	if (flash_pins_pkg::PAGE_COUNT * flash_pins_pkg::PAGE_BYTES !=
		flash_pins_pkg::BLOCK64_COUNT * flash_pins_pkg::BLOCK64_BYTES) begin : g_bad_geometry
		$error("array geometry does not agree");
	end

	// ************************************************************
	// Pin capture
	// ************************************************************
	logic [5:0] pin_lvl;
	logic [5:0] pin_rise;
	logic [5:0] pin_fall;

	pin_sampler #(.WIDTH(6), .IDLE(6'h0E)) u_sampler (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_pins({i_dual_line_one, i_dual_line_zero, i_write_protect_n, i_pause_n,
			i_cs_n, i_sclk}),
		.o_level(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	// ************************************************************
	// State
	// ************************************************************
	flash_pins_pkg::phase_type st_q, st_d;
	flash_pins_pkg::source_type src_q, src_d;
	logic armed_q, armed_d, active_q, active_d, pause_q, pause_d;
	logic done_q, done_d, cont_q, cont_d, drive_q, drive_d;
	logic dual_in_q, dual_in_d, dual_out_q, dual_out_d;
	logic [5:0] cnt_q, cnt_d;
	logic [2:0] ocnt_q, ocnt_d;
	logic [23:0] sh_q, sh_d;
	logic [7:0] op_q, op_d, tx_q, tx_d, next_q, next_d, wbyte_q, wbyte_d;
	logic [1:0] dout_q, dout_d;
	logic [flash_pins_pkg::ADDR_W-1:0] addr_q, addr_d, maddr_q, maddr_d;
	logic rd_q, rd_d, wr_q, wr_d, erase_q, erase_d;
	logic [7:0] wdata_q, wdata_d, sr_q, sr_d;
	logic [1:0] ekind_q, ekind_d;

	// ************************************************************
	// Decoded pin events
	// ************************************************************
	wire sclk_lvl = pin_lvl[0];
	wire cs_lvl = pin_lvl[1];
	wire pause_n_lvl = pin_lvl[2];
	wire wp_n_lvl = pin_lvl[3];
	wire cs_fall = pin_fall[1];
	wire cs_rise = pin_rise[1];
	wire ev_rise = pin_rise[0] & active_q & ~pause_q;
	wire ev_fall = pin_fall[0] & active_q & ~pause_q;
	wire [1:0] range = {sr_q[flash_pins_pkg::SR_RANGE_HI], sr_q[flash_pins_pkg::SR_RANGE_LO]};
	wire from_bottom = sr_q[flash_pins_pkg::SR_FROM_BOTTOM];
	wire wel = sr_q[flash_pins_pkg::SR_WEL];
	wire sr_locked = sr_q[flash_pins_pkg::SR_LOCK] & ~wp_n_lvl;
	wire addr_prot = flash_pins_pkg::is_protected(addr_q, range, from_bottom);

	// Inbound shift: one line in single mode, two in dual
	wire [23:0] sh_n = dual_in_q ? {sh_q[21:0], pin_lvl[5], pin_lvl[4]}
		: {sh_q[22:0], pin_lvl[4]};
	wire [5:0] cnt_n = cnt_q + (dual_in_q ? 6'h02 : 6'h01);
	wire [7:0] rx_byte = sh_n[7:0];
	wire [5:0] dummy_len = (op_q == flash_pins_pkg::OP_UID) ? flash_pins_pkg::UID_DUMMY_BITS
		: flash_pins_pkg::FAST_DUMMY_BITS;

	// Outbound byte and the address after it
	wire [7:0] out_byte = (ocnt_q == 3'h0) ? next_q : tx_q;
	wire [flash_pins_pkg::ADDR_W-1:0] addr_inc = addr_q + 1'b1;
	wire [flash_pins_pkg::ADDR_W-1:0] page_inc = {addr_q[flash_pins_pkg::ADDR_W-1:8],
		addr_q[7:0] + 8'h01};

	// Identification bytes by index
	wire [5:0] uid_shift = 6'(6'h38 - {maddr_q[2:0], 3'h0});
	wire [7:0] uid_byte = 8'(UNIQUE_ID >> uid_shift);
	wire [7:0] jedec_byte = (maddr_q[1:0] == 2'h0) ? MFR_ID
		: (maddr_q[1:0] == 2'h1) ? MEM_TYPE : CAP_ID;
	wire [7:0] src_byte = (src_q == flash_pins_pkg::SRC_STAT) ? sr_q
		: (src_q == flash_pins_pkg::SRC_JEDEC) ? jedec_byte
		: (src_q == flash_pins_pkg::SRC_MFR_DEV) ? (maddr_q[0] ? DEV_ID : MFR_ID)
		: (src_q == flash_pins_pkg::SRC_UID) ? uid_byte : i_mem_rdata;

	// Erase region base: clear the offset within the region
	wire [flash_pins_pkg::ADDR_W-1:0] base_4k = addr_q & ~18'(flash_pins_pkg::SECTOR_BYTES - 1);
	wire [flash_pins_pkg::ADDR_W-1:0] base_32k = addr_q & ~18'(flash_pins_pkg::BLOCK32_BYTES - 1);
	wire [flash_pins_pkg::ADDR_W-1:0] base_64k = addr_q & ~18'(flash_pins_pkg::BLOCK64_BYTES - 1);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		st_d = st_q;
		src_d = src_q;
		armed_d = armed_q | cs_lvl;
		active_d = active_q;
		pause_d = pause_q;
		done_d = done_q;
		cont_d = cont_q;
		drive_d = drive_q;
		dual_in_d = dual_in_q;
		dual_out_d = dual_out_q;
		cnt_d = cnt_q;
		ocnt_d = ocnt_q;
		sh_d = sh_q;
		op_d = op_q;
		tx_d = tx_q;
		next_d = rd_q ? src_byte : next_q;
		wbyte_d = wbyte_q;
		dout_d = dout_q;
		addr_d = addr_q;
		maddr_d = maddr_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		erase_d = 1'b0;
		wdata_d = wdata_q;
		ekind_d = ekind_q;
		sr_d = sr_q;
		sr_d[flash_pins_pkg::SR_BUSY] = i_busy;
		if (cs_rise) begin
			// Commit finished instructions, drop partial ones
			if (active_q && done_q) begin
				unique case (op_q)
					flash_pins_pkg::OP_WREN: sr_d[flash_pins_pkg::SR_WEL] = 1'b1;
					flash_pins_pkg::OP_WRDI: sr_d[flash_pins_pkg::SR_WEL] = 1'b0;
					flash_pins_pkg::OP_WRSR: begin
						if (wel && !sr_locked) begin
							sr_d = (sr_q & ~flash_pins_pkg::SR_WRITE_MASK) |
								(wbyte_q & flash_pins_pkg::SR_WRITE_MASK);
							sr_d[flash_pins_pkg::SR_WEL] = 1'b0;
						end
					end
					flash_pins_pkg::OP_PROG: sr_d[flash_pins_pkg::SR_WEL] = 1'b0;
					flash_pins_pkg::OP_ERASE4K, flash_pins_pkg::OP_ERASE32K,
					flash_pins_pkg::OP_ERASE64K: begin
						if (wel && !addr_prot) begin
							erase_d = 1'b1;
							ekind_d = (op_q == flash_pins_pkg::OP_ERASE4K) ? flash_pins_pkg::ERASE_4K
								: (op_q == flash_pins_pkg::OP_ERASE32K) ? flash_pins_pkg::ERASE_32K
								: flash_pins_pkg::ERASE_64K;
							maddr_d = (op_q == flash_pins_pkg::OP_ERASE4K) ? base_4k
								: (op_q == flash_pins_pkg::OP_ERASE32K) ? base_32k : base_64k;
							sr_d[flash_pins_pkg::SR_WEL] = 1'b0;
						end
					end
					flash_pins_pkg::OP_CHIP_A, flash_pins_pkg::OP_CHIP_B: begin
						if (wel && range == 2'h0) begin
							erase_d = 1'b1;
							ekind_d = flash_pins_pkg::ERASE_CHIP;
							maddr_d = '0;
							sr_d[flash_pins_pkg::SR_WEL] = 1'b0;
						end
					end
					default: ;
				endcase
			end
			st_d = flash_pins_pkg::ST_CMD;
			active_d = 1'b0;
			pause_d = 1'b0;
			done_d = 1'b0;
			drive_d = 1'b0;
			cnt_d = '0;
		end else if (cs_fall && armed_q) begin
			// Continuous mode skips the opcode and goes straight to address
			active_d = 1'b1;
			cnt_d = '0;
			ocnt_d = '0;
			done_d = 1'b0;
			st_d = cont_q ? flash_pins_pkg::ST_ADDR : flash_pins_pkg::ST_CMD;
			dual_in_d = cont_q;
			dual_out_d = cont_q;
		end else begin
			// Pause enters or leaves only while the clock is low
			if (active_q && !sclk_lvl && (pause_q == pause_n_lvl)) begin
				pause_d = ~pause_n_lvl;
			end
			if (ev_rise) begin
				sh_d = sh_n;
				cnt_d = cnt_n;
				unique case (st_q)
					flash_pins_pkg::ST_CMD: begin
						if (cnt_n == flash_pins_pkg::BYTE_BITS) begin
							op_d = rx_byte;
							cnt_d = '0;
							dual_out_d = (rx_byte == flash_pins_pkg::OP_DOUT) ||
								(rx_byte == flash_pins_pkg::OP_DIO);
							dual_in_d = rx_byte == flash_pins_pkg::OP_DIO;
							st_d = flash_pins_pkg::ST_IGNORE;
							if (!i_busy || rx_byte == flash_pins_pkg::OP_RDSR) begin
								unique case (rx_byte)
									flash_pins_pkg::OP_WREN, flash_pins_pkg::OP_WRDI,
									flash_pins_pkg::OP_CHIP_A, flash_pins_pkg::OP_CHIP_B:
										done_d = 1'b1;
									flash_pins_pkg::OP_RDSR, flash_pins_pkg::OP_JEDEC: begin
										st_d = flash_pins_pkg::ST_RDATA;
										src_d = (rx_byte == flash_pins_pkg::OP_RDSR) ?
											flash_pins_pkg::SRC_STAT : flash_pins_pkg::SRC_JEDEC;
										addr_d = '0;
										maddr_d = '0;
										rd_d = 1'b1;
									end
									flash_pins_pkg::OP_UID: begin
										st_d = flash_pins_pkg::ST_DUMMY;
										src_d = flash_pins_pkg::SRC_UID;
										addr_d = '0;
									end
									flash_pins_pkg::OP_WRSR: st_d = flash_pins_pkg::ST_WDATA;
									flash_pins_pkg::OP_READ, flash_pins_pkg::OP_FAST,
									flash_pins_pkg::OP_DOUT, flash_pins_pkg::OP_DIO,
									flash_pins_pkg::OP_PROG, flash_pins_pkg::OP_ERASE4K,
									flash_pins_pkg::OP_ERASE32K, flash_pins_pkg::OP_ERASE64K,
									flash_pins_pkg::OP_MFR_DEV: st_d = flash_pins_pkg::ST_ADDR;
									default: ;
								endcase
							end
						end
					end
					flash_pins_pkg::ST_ADDR: begin
						if (cnt_n == flash_pins_pkg::ADDR_BITS) begin
							addr_d = sh_n[flash_pins_pkg::ADDR_W-1:0];
							maddr_d = sh_n[flash_pins_pkg::ADDR_W-1:0];
							cnt_d = '0;
							src_d = (op_q == flash_pins_pkg::OP_MFR_DEV) ?
								flash_pins_pkg::SRC_MFR_DEV : flash_pins_pkg::SRC_MEM;
							unique case (op_q)
								flash_pins_pkg::OP_READ, flash_pins_pkg::OP_MFR_DEV: begin
									st_d = flash_pins_pkg::ST_RDATA;
									rd_d = 1'b1;
								end
								flash_pins_pkg::OP_FAST, flash_pins_pkg::OP_DOUT:
									st_d = flash_pins_pkg::ST_DUMMY;
								flash_pins_pkg::OP_DIO: st_d = flash_pins_pkg::ST_MODE;
								flash_pins_pkg::OP_PROG: st_d = flash_pins_pkg::ST_WDATA;
								default: begin
									st_d = flash_pins_pkg::ST_IGNORE;
									done_d = 1'b1;
								end
							endcase
						end
					end
					flash_pins_pkg::ST_MODE: begin
						if (cnt_n == flash_pins_pkg::BYTE_BITS) begin
							cont_d = rx_byte[5:4] == flash_pins_pkg::CONT_MODE_CODE;
							cnt_d = '0;
							st_d = flash_pins_pkg::ST_RDATA;
							rd_d = 1'b1;
						end
					end
					flash_pins_pkg::ST_DUMMY: begin
						if (cnt_n == dummy_len) begin
							cnt_d = '0;
							st_d = flash_pins_pkg::ST_RDATA;
							rd_d = 1'b1;
						end
					end
					flash_pins_pkg::ST_WDATA: begin
						if (cnt_n == flash_pins_pkg::BYTE_BITS) begin
							cnt_d = '0;
							wbyte_d = rx_byte;
							done_d = 1'b1;
							if (op_q == flash_pins_pkg::OP_PROG && wel && !addr_prot) begin
								wr_d = 1'b1;
								wdata_d = rx_byte;
								maddr_d = addr_q;
								addr_d = page_inc;
							end
						end
					end
					flash_pins_pkg::ST_RDATA: ;
					flash_pins_pkg::ST_IGNORE: done_d = 1'b0;
				endcase
			end
			if (ev_fall && st_q == flash_pins_pkg::ST_RDATA) begin
				// Drive on the fall; the next byte is prefetched one ahead
				drive_d = 1'b1;
				if (dual_out_q) begin
					dout_d = out_byte[7:6];
					tx_d = {out_byte[5:0], 2'h0};
					ocnt_d = ocnt_q + 3'h2;
				end else begin
					dout_d = {out_byte[7], 1'b0};
					tx_d = {out_byte[6:0], 1'b0};
					ocnt_d = ocnt_q + 3'h1;
				end
				if (ocnt_q == 3'h0) begin
					addr_d = addr_inc;
					maddr_d = addr_inc;
					rd_d = 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= flash_pins_pkg::ST_CMD;
			src_q <= flash_pins_pkg::SRC_MEM;
			{armed_q, active_q, pause_q, done_q, cont_q, drive_q} <= 6'h00;
			{dual_in_q, dual_out_q, rd_q, wr_q, erase_q} <= 5'h00;
			{cnt_q, ocnt_q, dout_q, ekind_q} <= 13'h0000;
			{sh_q, op_q, tx_q, next_q, wbyte_q, wdata_q} <= 64'h0000000000000000;
			{addr_q, maddr_q} <= 36'h000000000;
			sr_q <= flash_pins_pkg::SR_RESET;
		end else begin
			st_q <= st_d;
			src_q <= src_d;
			{armed_q, active_q, pause_q, done_q, cont_q, drive_q} <=
				{armed_d, active_d, pause_d, done_d, cont_d, drive_d};
			{dual_in_q, dual_out_q, rd_q, wr_q, erase_q} <=
				{dual_in_d, dual_out_d, rd_d, wr_d, erase_d};
			{cnt_q, ocnt_q, dout_q, ekind_q} <= {cnt_d, ocnt_d, dout_d, ekind_d};
			{sh_q, op_q, tx_q, next_q, wbyte_q, wdata_q} <=
				{sh_d, op_d, tx_d, next_d, wbyte_d, wdata_d};
			{addr_q, maddr_q} <= {addr_d, maddr_d};
			sr_q <= sr_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Float while deselected or paused; drive only after the first fall
	assign o_dual_line_one_oe = drive_q & active_q & ~pause_q;
	assign o_dual_line_zero_oe = drive_q & active_q & ~pause_q & dual_out_q;
	assign o_dual_line_one = dout_q[1];
	assign o_dual_line_zero = dout_q[0];
	assign o_mem_addr = maddr_q;
	assign o_mem_rd = rd_q & (src_q == flash_pins_pkg::SRC_MEM);
	assign o_mem_wr = wr_q;
	assign o_mem_wdata = wdata_q;
	assign o_erase_req = erase_q;
	assign o_erase_kind = ekind_q;
	assign o_status = sr_q;
	assign o_selected = active_q;
	assign o_paused = pause_q;

endmodule : flash_pin_port

// ---- bench/flash_pin_port_assertions.sv ----
// ********
// Pin port checker
// ********
module flash_pin_port_assertions (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// Pins
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic i_write_protect_n,
	input wire logic i_pause_n,
	// Design outputs
	input wire logic o_dual_line_zero_oe,
	input wire logic o_dual_line_one,
	input wire logic o_dual_line_one_oe,
	input wire logic [flash_pins_pkg::ADDR_W-1:0] o_mem_addr,
	input wire logic o_mem_rd,
	input wire logic o_mem_wr,
	input wire logic o_erase_req,
	input wire logic [1:0] o_erase_kind,
	input wire logic [7:0] o_status,
	input wire logic o_selected,
	input wire logic o_paused
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// Six cycles covers the pin filter plus the enable drop
	desel_float_a: assert property (i_cs_n [*6] |-> !o_dual_line_zero_oe && !o_dual_line_one_oe)
		else $error("Data line driven while deselected");
	// Pause pin low with the clock low must float the lines through the filter
	pause_float_a: assert property ((!i_pause_n && !i_sclk && o_selected) [*6]
		|-> !o_dual_line_zero_oe && !o_dual_line_one_oe)
		else $error("Data line driven while paused");
	fall_drive_a: assert property (o_dual_line_one_oe && $past(o_dual_line_one_oe)
		&& $changed(o_dual_line_one) |-> !$past(i_sclk, 2)) else $error("Output moved off a fall");
	read_framed_a: assert property (o_mem_rd |-> o_selected)
		else $error("Array read outside a frame");
	pause_still_a: assert property (o_paused [*2] |-> !o_mem_rd && !o_mem_wr)
		else $error("Array access while paused");
	write_pulse_a: assert property (o_mem_wr |-> o_status[1] ##1 !o_mem_wr)
		else $error("Bad program pulse");
	erase_base_a: assert property (o_erase_req |-> o_erase_kind == 2'h3
		|| (o_erase_kind == 2'h0 && o_mem_addr[11:0] == 12'h000)
		|| (o_erase_kind == 2'h1 && o_mem_addr[14:0] == 15'h0000)
		|| (o_erase_kind == 2'h2 && o_mem_addr[15:0] == 16'h0000)) else $error("Erase not aligned");
	erase_commit_a: assert property (o_erase_req |-> $past(i_cs_n, 3) ##1 !o_erase_req)
		else $error("Erase before deselect");
	lock_hold_a: assert property ($past(o_status[7]) && !$past(i_write_protect_n, 6)
		&& !$past(i_write_protect_n) |-> $stable(o_status & 8'hAC)) else $error("Locked status moved");
	// Main scenarios
	cover property (o_erase_req);
	cover property (o_paused ##[1:100] !o_paused);
	cover property (o_mem_wr ##[1:200] o_mem_wr);
endmodule : flash_pin_port_assertions

bind flash_pin_port flash_pin_port_assertions u_chk (.i_mclk, .i_reset_n, .i_cs_n, .i_sclk,
	.i_write_protect_n, .i_pause_n, .o_dual_line_zero_oe, .o_dual_line_one,
	.o_dual_line_one_oe, .o_mem_addr, .o_mem_rd, .o_mem_wr, .o_erase_req, .o_erase_kind,
	.o_status, .o_selected, .o_paused);

// ---- bench/spi_host_model.sv ----
// ********
// Serial host
// ********
module spi_host_model (
	// Clock
	input wire logic i_mclk,
	// Device data lines
	input wire logic i_out0,
	input wire logic i_oe0,
	input wire logic i_out1,
	input wire logic i_oe1,
	// Pins towards the device
	output logic o_cs_n,
	output logic o_sclk,
	output logic o_pause_n,
	output wire logic o_line0,
	output wire logic o_line1
);
	timeunit 1ns;
	timeprecision 1ps;
	logic d0;
	logic d1;
	// Idle pins; in single transfers line one toggles so a stale bit cannot match
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_pause_n = 1'b1;
		d0 = 1'b0;
		d1 = 1'b0;
	end
	assign o_line0 = i_oe0 ? i_out0 : d0;
	assign o_line1 = i_oe1 ? i_out1 : d1;
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : tick
	// Select only after a high select; clock idles low
	task automatic start();
		@(posedge i_mclk) o_cs_n <= 1'b0;
		tick(6);
	endtask : start
	task automatic stop();
		@(posedge i_mclk) o_sclk <= 1'b0;
		tick(6);
		o_cs_n <= 1'b1;
		tick(12);
	endtask : stop
	// Phases of seven cycles; the pin filter needs at least four
	task automatic xfer(input logic [7:0] tx, input int n, input bit hold, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			@(posedge i_mclk) o_sclk <= 1'b0;
			// Four clocks carry a byte on both lines, high bit on line one
			d0 <= (n == 4) ? tx[6-2*i] : tx[7-i];
			d1 <= (n == 4) ? tx[7-2*i] : ~d1;
			tick(6);
			if (hold && i == 4) begin
				o_pause_n <= 1'b0;
				tick(8);
				o_sclk <= 1'b1;
				d0 <= ~d0;
				tick(6);
				o_sclk <= 1'b0;
				tick(6);
				o_pause_n <= 1'b1;
				tick(8);
			end
			@(posedge i_mclk) o_sclk <= 1'b1;
			if (n == 4) rx[7-2*i -: 2] = {o_line1, o_line0};
			else rx[7-i] = o_line1;
			tick(6);
		end
	endtask : xfer
endmodule : spi_host_model

// ---- bench/tb_serial_flash_spi_pin_interface.sv ----
// ********
// Bench top
// ********
module tb_serial_flash_spi_pin_interface;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MFR = 8'hA7; // Arbitrary value
	localparam logic [7:0] TYP = 8'h41; // Arbitrary value
	localparam logic [7:0] CAP = 8'h2C; // Arbitrary value
	localparam logic [7:0] ERS [3] = '{8'h20, 8'h52, 8'hD8};
	localparam logic [17:0] MSK [3] = '{18'h3F000, 18'h38000, 18'h30000};
	logic i_mclk, i_reset_n, i_write_protect_n, cs_n, sclk, pause_n, line0, line1;
	logic out0, oe0, out1, oe1, mem_wr, mem_rd, erase_req;
	logic [flash_pins_pkg::ADDR_W-1:0] mem_addr;
	logic [1:0] erase_kind;
	logic [7:0] mem_rdata, mem_wdata, status, rx;
	logic [23:0] a;
	logic [15:0] pb;
	logic [31:0] seed = 32'h4DBA;
	logic [31:0] wr_q [$];
	logic [31:0] er_q [$];
	int err_total = 0;
	int checked = 0;
	flash_pin_port #(.MFR_ID(MFR), .MEM_TYPE(TYP), .CAP_ID(CAP)) u_dut (.i_mclk(i_mclk),
		.i_reset_n(i_reset_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_write_protect_n(i_write_protect_n),
		.i_pause_n(pause_n), .i_dual_line_zero(line0), .o_dual_line_zero(out0),
		.o_dual_line_zero_oe(oe0), .i_dual_line_one(line1), .o_dual_line_one(out1),
		.o_dual_line_one_oe(oe1), .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .i_mem_rdata(mem_rdata),
		.o_mem_wr(mem_wr), .o_mem_wdata(mem_wdata), .o_erase_req(erase_req),
		.o_erase_kind(erase_kind),
		.i_busy(1'b0), .o_status(status), .o_selected(), .o_paused());
	spi_host_model u_host (.i_mclk(i_mclk), .i_out0(out0), .i_oe0(oe0), .i_out1(out1),
		.i_oe1(oe1), .o_cs_n(cs_n), .o_sclk(sclk), .o_pause_n(pause_n), .o_line0(line0),
		.o_line1(line1));
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	// Array model answers at once: the port takes the byte during its read pulse
	assign mem_rdata = mem_addr[7:0] ^ 8'h3C;
	// Log writes with their data, and erases
	always @(posedge i_mclk) begin
		if (mem_wr === 1'b1) wr_q.push_back(32'({mem_wdata, mem_addr}));
		if (erase_req === 1'b1) er_q.push_back(32'({erase_kind, mem_addr}));
	end
	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : next_rand
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask : chk
	task automatic give_verdict();
		if (err_total == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic send(input logic [7:0] b);
		u_host.xfer(b, 8, 1'b0, rx);
	endtask : send
	task automatic op(input logic [7:0] c);
		u_host.start();
		send(c);
		u_host.stop();
	endtask : op
	task automatic addr_op(input logic [7:0] c, input logic [23:0] ad);
		u_host.start();
		send(c);
		send(ad[23:16]);
		send(ad[15:8]);
		send(ad[7:0]);
	endtask : addr_op
	task automatic wrsr(input logic [7:0] v);
		op(8'h06);
		u_host.start();
		send(8'h01);
		send(v);
		u_host.stop();
	endtask : wrsr
	// Main sequence
	initial begin
		i_reset_n = 1'b0;
		i_write_protect_n = 1'b1;
		repeat (16) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		u_host.tick(10);
		u_host.start();
		u_host.xfer(8'h9F, 4, 1'b0, rx);
		u_host.stop();
		u_host.start();
		send(8'h9F);
		send(8'h00);
		chk(rx, MFR);
		u_host.xfer(8'h00, 8, 1'b1, rx);
		chk(rx, TYP);
		send(8'h00);
		chk(rx, CAP);
		u_host.stop();
		op(8'h06);
		u_host.start();
		send(8'h05);
		send(8'h00);
		chk(rx, 8'h02);
		u_host.stop();
		wrsr(8'h80);
		chk(status & 8'hAC, 8'h80);
		@(posedge i_mclk) i_write_protect_n <= 1'b0;
		wrsr(8'h8C);
		chk(status & 8'hAC, 8'h80);
		@(posedge i_mclk) i_write_protect_n <= 1'b1;
		wrsr(8'h00);
		chk(status & 8'hAC, 8'h00);
		repeat (2) begin
			a = 24'(next_rand() & 32'h3FF7F);
			addr_op(8'h03, a);
			for (int i = 0; i < 3; i++) begin
				send(8'h00);
				chk(rx, 8'(a + 24'(i)) ^ 8'h3C);
			end
			u_host.stop();
		end
		// Program past the page end: the address must wrap inside the page
		a = 24'((next_rand() & 32'h3FF00) | 32'hFF);
		op(8'h06);
		addr_op(8'h02, a);
		pb = 16'(next_rand());
		send(pb[15:8]);
		send(pb[7:0]);
		u_host.stop();
		chk(wr_q.size(), 2);
		chk(wr_q[0], 32'({pb[15:8], a[17:0]}));
		chk(wr_q[1], 32'({pb[7:0], a[17:8], 8'h00}));
		for (int k = 0; k < 3; k++) begin
			a = 24'(next_rand() & 32'h3FFFF);
			op(8'h06);
			addr_op(ERS[k], a);
			u_host.stop();
			chk(er_q.size(), 1);
			chk(er_q[0], 32'({2'(k), a[17:0] & MSK[k]}));
			er_q.delete();
		end
		// Dual I/O read; the second frame starts in continuous mode, no opcode
		for (int f = 0; f < 2; f++) begin
			a = 24'(next_rand() & 32'h3FF7F);
			u_host.start();
			if (f == 0) send(8'hBB);
			for (int j = 2; j >= 0; j--) u_host.xfer(a[8*j +: 8], 4, 1'b0, rx);
			u_host.xfer((f == 0) ? 8'h20 : 8'h00, 4, 1'b0, rx);
			for (int i = 0; i < 2; i++) begin
				u_host.xfer(8'h00, 4, 1'b0, rx);
				chk(rx, 8'(a + 24'(i)) ^ 8'h3C);
			end
			u_host.stop();
		end
		give_verdict();
	end
endmodule : tb_serial_flash_spi_pin_interface
